// ### logic/am_depth_consts.vh
// Purpose: constants for the am depth calibration block
// Assumes: axi4-lite word registers, byte addresses below
// Notes:   offsets chosen for this block
//
// Overview of operation
// - keying type select bit picks on-off keying or amplitude modulation.
// - preset command selects amplitude modulation for any nonzero protocol code.
// - depth source bit 7: zero uses calibration, one uses software level.
// - target equals measurement divided by one plus depth code fraction.
// - each driver output has eight binary-weighted segments, off raises resistance.
// - all segments on when unmodulated unless normal level register says otherwise.
// - calibration first enables transmitter with unmodulated level.
// - unmodulated amplitude is digitised and stored in converter output register.
// - target modulated level computed from measurement and depth code.
// - driver strength tuned by successive approximation toward target.
// - result written to depth display register and used as modulated level.
// - source bit one takes modulated level straight from software register.
// - equal-weight tuning switches in both banks share one control.
// - tuning switches set by tank tuning or by calibration control register.
`ifndef AM_DEPTH_CONSTS_VH
`define AM_DEPTH_CONSTS_VH

// ==========================================================
// register byte offsets
`define OFS_AUX_DEF        8'h00
`define OFS_DEPTH_CTRL     8'h04
`define OFS_DEPTH_DISP     8'h08
`define OFS_MOD_LEVEL      8'h0c
`define OFS_NORM_LEVEL     8'h10
`define OFS_ADC_OUT        8'h14
`define OFS_ANT_CTRL       8'h18
`define OFS_COMMAND        8'h1c
`define OFS_STATUS         8'h20

// ==========================================================
// field positions
`define BIT_KEYING_AM      0
`define BIT_SOURCE_SW      7
`define BIT_ANT_MANUAL     7
`define CMD_PRESET         8'h01
`define CMD_CAL_DEPTH      8'h02
`define CMD_MEASURE        8'h03
`define CMD_CAL_ANT        8'h04

// ==========================================================
// reset values and timing
`define RST_DEPTH_CTRL     8'h00
`define RST_NORM_LEVEL     8'h00
`define SETTLE_NS          2000
`define SETTLE_CYC         ((`SETTLE_NS + 99) / 100)

`endif

// ### logic/depth_divider.v
// Purpose: target = level / (1 + code/64), sequential restoring divide
// Assumes: start pulses only while idle
// Notes:   eight quotient bits, one per cycle
`timescale 1ns/1ps
module depth_divider (
    // clock
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       ce,
    // request
    input  wire       start,
    input  wire [7:0] level,
    input  wire [5:0] code,
    // answer
    output reg        done,
    output reg  [7:0] quot
);
    reg  [14:0] rem_reg;
    reg  [3:0]  cnt_reg;
    reg         busy_reg;
    wire [6:0]  divisor = {1'b1, code};
    wire [14:0] trial = {rem_reg[13:0], 1'b0};
    wire [14:0] dsh = {2'b00, divisor, 6'h00};

    // level*64 / (64+code), bit by bit
    always @(posedge aclk) begin
        if (!aresetn) begin
            rem_reg <= 15'h0000;
            cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            done <= 1'b0;
            quot <= 8'h00;
        end else if (ce) begin
            done <= 1'b0;
            if (start && !busy_reg) begin
                rem_reg <= {2'b00, level, 5'h00};
                cnt_reg <= 4'h8;
                busy_reg <= 1'b1;
                quot <= 8'h00;
            end else if (busy_reg) begin
                if (trial[14:7] >= {1'b0, divisor}) begin
                    rem_reg <= {trial[14:7] - {1'b0, divisor}, trial[6:0]};
                    quot <= {quot[6:0], 1'b1};
                end else begin
                    rem_reg <= trial;
                    quot <= {quot[6:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    busy_reg <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ### logic/am_depth_calibration.v
// Purpose: modulation keying and am level control with depth calibration
// Assumes: adc and amplitude detector outside; amplitude sampled on request
// Notes:   registers over axi4-lite, one word each
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "am_depth_consts.vh"
module am_depth_calibration #(
    parameter SEGMENTS = 8,
    parameter SETTLE   = `SETTLE_CYC
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    // axi4-lite write
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // analog front end
    input  wire [2:0]  protocol_sel,
    input  wire [7:0]  sense_amplitude,
    input  wire [3:0]  ant_tune_result,
    input  wire        ant_tune_done,
    input  wire        modulate,
    output reg         tx_enable,
    output reg         keying_type_select,
    output reg  [7:0]  driver_output_one,
    output reg  [7:0]  driver_output_two,
    output reg  [3:0]  tune_switch_bank_a,
    output reg  [3:0]  tune_switch_bank_b,
    output reg         ant_tune_start
);
    // ======================================================
    // states
    localparam S_IDLE   = 5'b00001;
    localparam S_SETTLE = 5'b00010;
    localparam S_DIV    = 5'b00100;
    localparam S_TRY    = 5'b01000;
    localparam S_JUDGE  = 5'b10000;

    // ======================================================
    // registers
    reg  [7:0]  aux_reg;
    reg  [7:0]  depth_ctrl_reg;
    reg  [7:0]  depth_disp_reg;
    reg  [7:0]  mod_level_reg;
    reg  [7:0]  norm_level_reg;
    reg  [7:0]  adc_reg;
    reg  [7:0]  ant_ctrl_reg;
    reg  [3:0]  ant_auto_reg;
    reg  [4:0]  state_reg;
    reg  [15:0] timer_reg;
    reg  [7:0]  trial_reg;
    reg  [7:0]  target_reg;
    reg  [2:0]  bit_reg;
    reg         div_start;
    reg  [7:0]  aw_addr_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         aw_have;
    reg         w_have;
    wire        div_done;
    wire [7:0]  div_quot;
    wire        busy = (state_reg != S_IDLE);

    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `OFS_STATUS);
        end
    endfunction

    function [7:0] pick;
        input [7:0] old;
        input [31:0] d;
        input [3:0] s;
        begin
            pick = s[0] ? d[7:0] : old;
        end
    endfunction

    // ======================================================
    // divider
    depth_divider u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .start   (div_start),
        .level   (adc_reg),
        .code    (depth_ctrl_reg[6:1]),
        .done    (div_done),
        .quot    (div_quot)
    );

    // ======================================================
    // bus write and calibration engine
    wire do_write = aw_have && w_have && !s_axi_bvalid;
    wire [7:0] cmd = w_data_reg[7:0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            aux_reg <= 8'h00;
            depth_ctrl_reg <= `RST_DEPTH_CTRL;
            depth_disp_reg <= 8'h00;
            mod_level_reg <= 8'h00;
            norm_level_reg <= `RST_NORM_LEVEL;
            adc_reg <= 8'h00;
            ant_ctrl_reg <= 8'h00;
            ant_auto_reg <= 4'h0;
            ant_tune_start <= 1'b0;
            state_reg <= S_IDLE;
            timer_reg <= 16'h0000;
            trial_reg <= 8'h00;
            target_reg <= 8'h00;
            bit_reg <= 3'h0;
            div_start <= 1'b0;
        end else if (ce) begin
            div_start <= 1'b0;
            ant_tune_start <= 1'b0;
            s_axi_awready <= !aw_have && !s_axi_awready;
            s_axi_wready <= !w_have && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (ant_tune_done)
                ant_auto_reg <= ant_tune_result;
            if (do_write) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr_reg) ? 2'b00 : 2'b10;
                case (aw_addr_reg)
                    `OFS_AUX_DEF:
                        aux_reg <= pick(aux_reg, w_data_reg, w_strb_reg);
                    `OFS_DEPTH_CTRL:
                        depth_ctrl_reg <=
                            pick(depth_ctrl_reg, w_data_reg, w_strb_reg);
                    `OFS_MOD_LEVEL:
                        mod_level_reg <=
                            pick(mod_level_reg, w_data_reg, w_strb_reg);
                    `OFS_NORM_LEVEL:
                        norm_level_reg <=
                            pick(norm_level_reg, w_data_reg, w_strb_reg);
                    `OFS_ANT_CTRL:
                        ant_ctrl_reg <=
                            pick(ant_ctrl_reg, w_data_reg, w_strb_reg);
                    `OFS_COMMAND: begin
                        if (w_strb_reg[0] && !busy) begin
                            if (cmd == `CMD_PRESET)
                                aux_reg[`BIT_KEYING_AM] <=
                                    (protocol_sel != 3'h0);
                            if (cmd == `CMD_CAL_ANT)
                                ant_tune_start <= 1'b1;
                            if (cmd == `CMD_CAL_DEPTH ||
                                cmd == `CMD_MEASURE) begin
                                state_reg <= S_SETTLE;
                                timer_reg <= SETTLE[15:0];
                                trial_reg <= {cmd == `CMD_CAL_DEPTH,
                                              7'h00};
                            end
                        end
                    end
                    default: ;
                endcase
            end
            case (state_reg)
                S_IDLE: ;
                S_SETTLE: begin
                    if (timer_reg != 16'h0000)
                        timer_reg <= timer_reg - 16'h0001;
                    else begin
                        adc_reg <= sense_amplitude;
                        if (trial_reg[7]) begin
                            div_start <= 1'b1;
                            state_reg <= S_DIV;
                        end else
                            state_reg <= S_IDLE;
                    end
                end
                S_DIV: begin
                    if (div_done) begin
                        target_reg <= div_quot;
                        bit_reg <= SEGMENTS[2:0] - 3'h1;
                        trial_reg <= 8'h80;
                        timer_reg <= SETTLE[15:0];
                        state_reg <= S_TRY;
                    end
                end
                S_TRY: begin
                    if (timer_reg != 16'h0000)
                        timer_reg <= timer_reg - 16'h0001;
                    else
                        state_reg <= S_JUDGE;
                end
                S_JUDGE: begin
                    // more segments off lowers the level
                    if (sense_amplitude < target_reg)
                        trial_reg[bit_reg] <= 1'b0;
                    if (bit_reg == 3'h0) begin
                        depth_disp_reg <= (sense_amplitude < target_reg) ?
                            (trial_reg & ~8'h01) : trial_reg;
                        state_reg <= S_IDLE;
                    end else begin
                        bit_reg <= bit_reg - 3'h1;
                        trial_reg[bit_reg - 3'h1] <= 1'b1;
                        timer_reg <= SETTLE[15:0];
                        state_reg <= S_TRY;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ======================================================
    // drivers and tuning switches
    reg [7:0] off_mask;
    always @* begin
        if (state_reg == S_TRY || state_reg == S_JUDGE)
            off_mask = trial_reg;
        else if (busy || !modulate)
            off_mask = norm_level_reg;
        else if (depth_ctrl_reg[`BIT_SOURCE_SW])
            off_mask = mod_level_reg;
        else
            off_mask = depth_disp_reg;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            driver_output_one <= 8'hff;
            driver_output_two <= 8'hff;
            tx_enable <= 1'b0;
            keying_type_select <= 1'b0;
            tune_switch_bank_a <= 4'h0;
            tune_switch_bank_b <= 4'h0;
        end else if (ce) begin
            // segment on when its bit is clear
            driver_output_one <= ~off_mask;
            driver_output_two <= ~off_mask;
            tx_enable <= busy || aux_reg[1];
            keying_type_select <= aux_reg[`BIT_KEYING_AM];
            // one source for both banks
            tune_switch_bank_a <= ant_ctrl_reg[`BIT_ANT_MANUAL] ?
                ant_ctrl_reg[3:0] : ant_auto_reg;
            tune_switch_bank_b <= ant_ctrl_reg[`BIT_ANT_MANUAL] ?
                ant_ctrl_reg[3:0] : ant_auto_reg;
        end
    end

    // ======================================================
    // bus read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
                case (s_axi_araddr)
                    `OFS_AUX_DEF:    s_axi_rdata <= {24'h0, aux_reg};
                    `OFS_DEPTH_CTRL: s_axi_rdata <= {24'h0, depth_ctrl_reg};
                    `OFS_DEPTH_DISP: s_axi_rdata <= {24'h0, depth_disp_reg};
                    `OFS_MOD_LEVEL:  s_axi_rdata <= {24'h0, mod_level_reg};
                    `OFS_NORM_LEVEL: s_axi_rdata <= {24'h0, norm_level_reg};
                    `OFS_ADC_OUT:    s_axi_rdata <= {24'h0, adc_reg};
                    `OFS_ANT_CTRL:   s_axi_rdata <= {24'h0, ant_ctrl_reg};
                    `OFS_STATUS:
                        s_axi_rdata <= {23'h0, busy, 4'h0, ant_auto_reg};
                    default:         s_axi_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ### verif/am_depth_calibration_checker.sv
// Purpose: port checks for am_depth_calibration
// Assumes: ce held high by the bench
// Notes:   bound into every instance of the block
`timescale 1ns/1ps
module am_depth_calibration_checker #(
    parameter SETTLE = 20
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    // bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // front end
    input wire logic [7:0]  driver_output_one,
    input wire logic [7:0]  driver_output_two,
    input wire logic [3:0]  tune_switch_bank_a,
    input wire logic [3:0]  tune_switch_bank_b,
    input wire logic        ant_tune_start
);
    // ==========================================================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bank_pair; tune_switch_bank_a == tune_switch_bank_b; endproperty
    a_bank_pair: assert property (p_bank_pair)
        else $error("tuning banks differ");
    property p_drv_pair; driver_output_one == driver_output_two; endproperty
    a_drv_pair: assert property (p_drv_pair)
        else $error("driver outputs differ");
    property p_drv_reset; $rose(aresetn) |-> driver_output_one == 8'hff;
    endproperty
    a_drv_reset: assert property (p_drv_reset)
        else $error("segments not all on after reset");
    property p_tune_pulse; ant_tune_start |=> !ant_tune_start; endproperty
    a_tune_pulse: assert property (p_tune_pulse)
        else $error("tuner start longer than one cycle");
    property p_aw_pulse; ce && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_pulse: assert property (p_aw_pulse)
        else $error("write address ready not a pulse");
    property p_r_answer;
        ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read data late");
    property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop)
        else $error("write response repeated");
    property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_drop: assert property (p_r_drop)
        else $error("read data repeated");
    property p_err_data;
        s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data)
        else $error("refused read returned data");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
    c_tune: cover property ($rose(ant_tune_start));
endmodule

bind am_depth_calibration am_depth_calibration_checker #(
    .SETTLE(SETTLE)
) u_checker (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .driver_output_one(driver_output_one),
    .driver_output_two(driver_output_two),
    .tune_switch_bank_a(tune_switch_bank_a),
    .tune_switch_bank_b(tune_switch_bank_b),
    .ant_tune_start(ant_tune_start)
);

// ### verif/afe_model.sv
// Purpose: field amplitude and tank tuner stand-in
// Assumes: amplitude follows enabled segments at once
// Notes:   tuner result shown only with its done pulse
`timescale 1ns/1ps
module afe_model #(
    parameter [3:0] TUNE_RESULT = 4'ha
) (
    // clock
    input wire logic        aclk,
    // from the block
    input wire logic        tx_enable,
    input wire logic [7:0]  drive,
    input wire logic        tune_start,
    // to the block
    output logic     [7:0]  amplitude,
    output logic            tune_done,
    output logic     [3:0]  tune_result
);
    int cnt = 0;
    // no carrier, no field
    assign amplitude = tx_enable ? drive : 8'h00;
    assign tune_done = (cnt == 1);
    assign tune_result = tune_done ? TUNE_RESULT : ~TUNE_RESULT;
    // slow tuner answer
    always @(posedge aclk) begin
        if (tune_start)
            cnt <= 6;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
endmodule

// ### verif/am_depth_calibration_tb.sv
// Purpose: register-level tests of am_depth_calibration
// Assumes: afe_model drives sense and tuner ports
// Notes:   settle steps shortened to 2 cycles
`timescale 1ns/1ps
`include "am_depth_consts.vh"
module am_depth_calibration_tb;
    logic        aclk = 0, aresetn = 0, ce = 1, modulate = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0, amp, drv1, drv2;
    logic [31:0] wdata = 0, rdata, rd_d;
    logic [3:0]  wstrb = 4'hf, tres, sw_a, sw_b;
    logic [2:0]  proto = 0;
    logic [1:0]  bresp, rresp, rd_r;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        tdone, tx_en, keying, tstart;
    int          error_cnt = 0, n_tests = 0, i, j, t;
    int          codes [5] = '{0, 4, 16, 32, 56};

    am_depth_calibration #(.SETTLE(2)) u_am_depth_calibration (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .protocol_sel(proto), .sense_amplitude(amp),
        .ant_tune_result(tres), .ant_tune_done(tdone),
        .modulate(modulate), .tx_enable(tx_en),
        .keying_type_select(keying), .driver_output_one(drv1),
        .driver_output_two(drv2), .tune_switch_bank_a(sw_a),
        .tune_switch_bank_b(sw_b), .ant_tune_start(tstart)
    );
    afe_model u_afe_model (
        .aclk(aclk), .tx_enable(tx_en), .drive(drv1), .tune_start(tstart),
        .amplitude(amp), .tune_done(tdone), .tune_result(tres)
    );

    initial begin
        forever #50 aclk = ~aclk;
    end

    // ==========================================================
    // bus and check tasks
    task chk(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        logic b;
        b = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            b = bvalid;
        end
        bready <= 1'b0;
    endtask
    task rd(input [7:0] a);
        logic r;
        r = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            r = rvalid;
        end
        rd_d = rdata;
        rd_r = rresp;
        rready <= 1'b0;
    endtask
    task rc(input [7:0] a, input [31:0] e);
        rd(a);
        chk(rd_d, e);
    endtask
    task idle;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 100; i++) begin
            rd(`OFS_STATUS);
            if (rd_d[8] === 1'b0) break;
        end
        chk(rd_d[8], 1'b0);
    endtask
    task settle;
        repeat (2) @(posedge aclk);
    endtask
    task fin(input string s);
        $display("test %s done", s);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // tests
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(`OFS_DEPTH_CTRL, 32'h0);
        rc(`OFS_NORM_LEVEL, 32'h0);
        chk(drv1, 8'hff);
        chk(tx_en, 1'b0);
        rd(8'h40);
        chk(rd_r, 2'b10);
        chk(rd_d, 32'h0);
        fin("reset");
        wr(`OFS_AUX_DEF, 32'h3);
        settle;
        chk(keying, 1);
        chk(tx_en, 1'b1);
        for (j = 0; j < 8; j++) begin
            wr(`OFS_AUX_DEF, 32'h0);
            settle;
            chk(keying, 0);
            proto <= j[2:0];
            wr(`OFS_COMMAND, `CMD_PRESET);
            idle;
            chk(keying, j != 0);
        end
        fin("keying");
        wr(`OFS_NORM_LEVEL, 32'h0f);
        settle;
        chk(drv1, 8'hf0);
        wr(`OFS_COMMAND, `CMD_MEASURE);
        idle;
        rc(`OFS_ADC_OUT, 32'hf0);
        wr(`OFS_NORM_LEVEL, 32'h0);
        fin("measure");
        wr(`OFS_ANT_CTRL, 32'h85);
        settle;
        chk({sw_a, sw_b}, 8'h55);
        wr(`OFS_ANT_CTRL, 32'h0);
        wr(`OFS_COMMAND, `CMD_CAL_ANT);
        repeat (12) @(posedge aclk);
        rd(`OFS_STATUS);
        chk({sw_a, sw_b, rd_d[3:0]}, 12'haaa);
        fin("antenna");
        wr(`OFS_AUX_DEF, 32'h1);
        for (j = 0; j < 5; j++) begin
            t = 16320 / (64 + codes[j]);
            wr(`OFS_DEPTH_CTRL, codes[j] << 1);
            wr(`OFS_COMMAND, `CMD_CAL_DEPTH);
            idle;
            rc(`OFS_ADC_OUT, 32'hff);
            rc(`OFS_DEPTH_DISP, 255 - t);
            modulate <= 1'b1;
            settle;
            chk(drv1, t);
            modulate <= 1'b0;
            settle;
            chk(drv1, 8'hff);
        end
        fin("calibrate");
        wr(`OFS_MOD_LEVEL, 32'h3c);
        wr(`OFS_DEPTH_CTRL, 32'h80);
        modulate <= 1'b1;
        settle;
        chk(drv1, 8'hc3);
        modulate <= 1'b0;
        rc(`OFS_DEPTH_CTRL, 32'h80);
        fin("software");
        report_and_stop;
    end

    initial begin
        repeat (30000) @(posedge aclk);
        error_cnt++;
        report_and_stop;
    end
endmodule
